// >>> logic/uop_uart.sv
// The address map and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "uop_params.svh"
// Behaviour
// - only sixteen listed bit rates are selectable, one per rate code
// - parity is always none; odd and even selections are refused
// - flow control is none or rts/cts; no software xon/xoff
// - break response code 0 sleeps, 1 ignores, 2 raises an event
// - cts change event delivered only when notify setting is nonzero
// - rts, tx, cts, rx each routed to a pin; 0xff means default
// - rts is driven only by the receive flow-control logic
// - transmitter cannot send a break condition
module uop_uart
	import uop_pkg::*;
#(
	parameter int CLK_HZ   = `UOP_CLK_HZ,
	parameter int NPINS    = 32,
	parameter int PIN_W    = 5,
	parameter int DEF_RTS  = 5,
	parameter int DEF_TX   = 6,
	parameter int DEF_CTS  = 7,
	parameter int DEF_RX   = 8
)(
	input  wire logic             mclk,
	input  wire logic             resetn,
	input  wire logic [7:0]       s_axi_awaddr,
	input  wire logic             s_axi_awvalid,
	output logic                  s_axi_awready,
	input  wire logic [31:0]      s_axi_wdata,
	input  wire logic [3:0]       s_axi_wstrb,
	input  wire logic             s_axi_wvalid,
	output logic                  s_axi_wready,
	output logic      [1:0]       s_axi_bresp,
	output logic                  s_axi_bvalid,
	input  wire logic             s_axi_bready,
	input  wire logic [7:0]       s_axi_araddr,
	input  wire logic             s_axi_arvalid,
	output logic                  s_axi_arready,
	output logic      [31:0]      s_axi_rdata,
	output logic      [1:0]       s_axi_rresp,
	output logic                  s_axi_rvalid,
	input  wire logic             s_axi_rready,
	input  wire logic [NPINS-1:0] pin_in,
	output logic      [NPINS-1:0] pin_out,
	output logic      [NPINS-1:0] pin_oe,
	output logic                  deep_sleep_req,
	output logic                  irq
);
	logic [31:0] ctrl;
	logic [31:0] baud;
	logic [31:0] pins;
	logic [`UOP_IRQ_BITS-1:0] irq_stat;
	logic [`UOP_IRQ_BITS-1:0] irq_mask;
	logic [`UOP_IRQ_BITS-1:0] ev;
	logic [7:0]  rx_data;
	logic        rx_full;
	logic [7:0]  tx_hold;
	logic        tx_hold_full;
	logic [15:0] tick_div;
	logic        aw_hold;
	logic        w_hold;
	logic [7:0]  aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic        wr_go;
	logic        rd_go;
	logic        wr_ok;
	logic        rd_ok;
	logic [31:0] next_rdata;
	logic        tx_take;
	logic        rx_take;

	// field views
	logic        flow_hw;
	uop_brk_t    brk_code;
	logic        cts_notify;
	logic [7:0]  rts_pin_c, tx_pin_c, cts_pin_c, rx_pin_c;
	logic [PIN_W-1:0] rts_pin, tx_pin, cts_pin, rx_pin;
	assign flow_hw    = ctrl[`UOP_CTRL_FLOW_BIT];
	assign brk_code   = uop_brk_t'(ctrl[`UOP_CTRL_BRK_LO+:2]);
	assign cts_notify = ctrl[`UOP_CTRL_CTSN_BIT];
	assign rts_pin_c  = pins[7:0];
	assign tx_pin_c   = pins[15:8];
	assign cts_pin_c  = pins[23:16];
	assign rx_pin_c   = pins[31:24];
	assign rts_pin = (rts_pin_c == `UOP_PIN_DEFAULT) ? PIN_W'(DEF_RTS) : rts_pin_c[PIN_W-1:0];
	assign tx_pin  = (tx_pin_c == `UOP_PIN_DEFAULT) ? PIN_W'(DEF_TX) : tx_pin_c[PIN_W-1:0];
	assign cts_pin = (cts_pin_c == `UOP_PIN_DEFAULT) ? PIN_W'(DEF_CTS) : cts_pin_c[PIN_W-1:0];
	assign rx_pin  = (rx_pin_c == `UOP_PIN_DEFAULT) ? PIN_W'(DEF_RX) : rx_pin_c[PIN_W-1:0];

	uop_baud_gen #(
		.CLK_HZ   (CLK_HZ)
	) u_baud (
		.mclk     (mclk),
		.resetn   (resetn),
		.rate_sel (baud[3:0]),
		.tick_div (tick_div)
	);

	// axi4-lite slave: address and data taken in either order
	assign s_axi_awready = !aw_hold && !s_axi_bvalid;
	assign s_axi_wready  = !w_hold && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign wr_go = aw_hold && w_hold && !s_axi_bvalid;
	assign rd_go = s_axi_arvalid && s_axi_arready;
	assign s_axi_bresp = wr_ok ? 2'b00 : 2'b10;
	assign s_axi_rresp = rd_ok ? 2'b00 : 2'b10;

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			aw_hold <= 1'b0;
			w_hold  <= 1'b0;
			aw_addr <= 8'h00;
			w_data  <= 32'h0;
			w_strb  <= 4'h0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_hold <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			else if (wr_go)
				aw_hold <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_hold <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			else if (wr_go)
				w_hold <= 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			s_axi_bvalid <= 1'b0;
			wr_ok        <= 1'b1;
		end
		else if (wr_go)
		begin
			s_axi_bvalid <= 1'b1;
			wr_ok <= (aw_addr == `UOP_OFF_CTRL) || (aw_addr == `UOP_OFF_BAUD) ||
				(aw_addr == `UOP_OFF_PINS) || (aw_addr == `UOP_OFF_IRQ_MASK) ||
				(aw_addr == `UOP_OFF_TXDATA);
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	// parity codes other than none are never stored; field stays none
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			ctrl     <= `UOP_CTRL_RESET;
			baud     <= `UOP_BAUD_RESET;
			pins     <= `UOP_PINS_RESET;
			irq_mask <= '0;
		end
		else if (wr_go && w_strb[0])
		begin
			unique case (aw_addr)
				`UOP_OFF_CTRL:
				begin
					ctrl[`UOP_CTRL_FLOW_BIT] <= w_data[`UOP_CTRL_FLOW_BIT];
					ctrl[`UOP_CTRL_BRK_LO+:2] <= (w_data[`UOP_CTRL_BRK_LO+:2] == 2'b11) ?
						ctrl[`UOP_CTRL_BRK_LO+:2] : w_data[`UOP_CTRL_BRK_LO+:2];
					ctrl[`UOP_CTRL_CTSN_BIT] <= w_data[`UOP_CTRL_CTSN_BIT];
					ctrl[`UOP_CTRL_DCE_BIT]  <= w_data[`UOP_CTRL_DCE_BIT];
				end
				`UOP_OFF_BAUD:     baud[3:0] <= w_data[3:0];
				`UOP_OFF_PINS:     pins[7:0] <= w_data[7:0];
				`UOP_OFF_IRQ_MASK: irq_mask <= w_data[`UOP_IRQ_BITS-1:0];
				default: ;
			endcase
			if (aw_addr == `UOP_OFF_PINS)
			begin
				if (w_strb[1]) pins[15:8]  <= w_data[15:8];
				if (w_strb[2]) pins[23:16] <= w_data[23:16];
				if (w_strb[3]) pins[31:24] <= w_data[31:24];
			end
		end
		else if (wr_go && aw_addr == `UOP_OFF_PINS)
		begin
			if (w_strb[1]) pins[15:8]  <= w_data[15:8];
			if (w_strb[2]) pins[23:16] <= w_data[23:16];
			if (w_strb[3]) pins[31:24] <= w_data[31:24];
		end
	end

	assign tx_take = wr_go && w_strb[0] && aw_addr == `UOP_OFF_TXDATA && !tx_hold_full;

	always_comb
	begin
		next_rdata = 32'h0;
		unique case (s_axi_araddr)
			`UOP_OFF_CTRL:     next_rdata = ctrl;
			`UOP_OFF_BAUD:     next_rdata = baud;
			`UOP_OFF_PINS:     next_rdata = pins;
			`UOP_OFF_STATUS:   next_rdata = {28'h0, pin_in[cts_pin], pin_out[rts_pin],
				rx_full, tx_hold_full};
			`UOP_OFF_IRQ_STAT: next_rdata = {{(32-`UOP_IRQ_BITS){1'b0}}, irq_stat};
			`UOP_OFF_IRQ_MASK: next_rdata = {{(32-`UOP_IRQ_BITS){1'b0}}, irq_mask};
			`UOP_OFF_RXDATA:   next_rdata = {24'h0, rx_data};
			default:           next_rdata = 32'h0;
		endcase
	end

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0;
			rd_ok        <= 1'b1;
		end
		else if (rd_go)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= next_rdata;
			rd_ok <= (s_axi_araddr <= `UOP_OFF_RXDATA) && (s_axi_araddr[1:0] == 2'b00);
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	assign rx_take = rd_go && s_axi_araddr == `UOP_OFF_RXDATA;

	// sticky events; an event in the clearing read cycle survives
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			irq_stat <= '0;
		else if (rd_go && s_axi_araddr == `UOP_OFF_IRQ_STAT)
			irq_stat <= ev;
		else
			irq_stat <= irq_stat | ev;
	end
	assign irq = |(irq_stat & irq_mask);

	// oversampling tick
	logic [15:0] tcnt;
	logic        tick;
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			tcnt <= 16'h0;
		else if (tcnt + 16'h1 >= tick_div)
			tcnt <= 16'h0;
		else
			tcnt <= tcnt + 16'h1;
	end
	assign tick = (tcnt + 16'h1 >= tick_div);

	// pin sampling and cts change detect
	logic rxd, ctsd, cts_q;
	assign rxd  = pin_in[rx_pin];
	assign ctsd = pin_in[cts_pin];
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			cts_q <= 1'b1;
		else
			cts_q <= ctsd;
	end

	// transmitter
	uop_tx_st_t  tx_st;
	logic [3:0]  tx_os;
	logic [2:0]  tx_bit;
	logic [7:0]  tx_sh;
	logic        txd;
	logic        tx_done;
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			tx_hold      <= 8'h0;
			tx_hold_full <= 1'b0;
		end
		else if (tx_take)
		begin
			tx_hold      <= w_data[7:0];
			tx_hold_full <= 1'b1;
		end
		else if (tx_st == UOP_TX_IDLE && tick && tx_hold_full && (!flow_hw || !ctsd))
			tx_hold_full <= 1'b0;
	end

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			tx_st  <= UOP_TX_IDLE;
			tx_os  <= 4'h0;
			tx_bit <= 3'h0;
			tx_sh  <= 8'h0;
			txd    <= 1'b1;
		end
		else if (tick)
		begin
			tx_os <= tx_os + 4'h1;
			unique case (tx_st)
				UOP_TX_IDLE:
				begin
					txd <= 1'b1;
					tx_os <= 4'h0;
					if (tx_hold_full && (!flow_hw || !ctsd))
					begin
						tx_sh <= tx_hold;
						tx_st <= UOP_TX_START;
						txd   <= 1'b0;
					end
				end
				UOP_TX_START:
					if (tx_os == 4'hf)
					begin
						tx_st  <= UOP_TX_DATA;
						tx_bit <= 3'h0;
						txd    <= tx_sh[0];
					end
				UOP_TX_DATA:
					if (tx_os == 4'hf)
					begin
						if (tx_bit == 3'h7)
						begin
							tx_st <= UOP_TX_STOP;
							txd   <= 1'b1;
						end
						else
						begin
							tx_bit <= tx_bit + 3'h1;
							txd    <= tx_sh[3'(tx_bit + 3'h1)];
						end
					end
				UOP_TX_STOP:
					if (tx_os == 4'hf)
						tx_st <= UOP_TX_IDLE;
			endcase
		end
	end
	assign tx_done = tick && tx_st == UOP_TX_STOP && tx_os == 4'hf;

	// receiver with break detect (all-zero frame, stop low)
	uop_rx_st_t  rx_st;
	logic [3:0]  rx_os;
	logic [2:0]  rx_bit;
	logic [7:0]  rx_sh;
	logic        rx_ev, ovr_ev, brk_ev;
	logic        rx_wait;
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			rx_st  <= UOP_RX_IDLE;
			rx_os  <= 4'h0;
			rx_bit <= 3'h0;
			rx_sh  <= 8'h0;
			rx_wait <= 1'b0;
		end
		else if (tick)
		begin
			rx_os <= rx_os + 4'h1;
			unique case (rx_st)
				UOP_RX_IDLE:
				begin
					rx_os <= 4'h0;
					if (!rxd)
						rx_st <= UOP_RX_START;
				end
				UOP_RX_START:
					if (rx_os == 4'h7)
					begin
						rx_os  <= 4'h0;
						rx_bit <= 3'h0;
						rx_st  <= rxd ? UOP_RX_IDLE : UOP_RX_DATA;
					end
				UOP_RX_DATA:
					if (rx_os == 4'hf)
					begin
						rx_sh <= {rxd, rx_sh[7:1]};
						rx_bit <= rx_bit + 3'h1;
						if (rx_bit == 3'h7)
							rx_st <= UOP_RX_STOP;
					end
				UOP_RX_STOP:
					// after a low stop, wait for line idle so a long break gives one event
					if (rx_wait)
					begin
						if (rxd)
						begin
							rx_wait <= 1'b0;
							rx_st   <= UOP_RX_IDLE;
						end
					end
					else if (rx_os == 4'hf)
					begin
						rx_wait <= !rxd;
						if (rxd)
							rx_st <= UOP_RX_IDLE;
					end
			endcase
		end
	end
	assign rx_ev  = tick && rx_st == UOP_RX_STOP && !rx_wait && rx_os == 4'hf && rxd;
	assign brk_ev = tick && rx_st == UOP_RX_STOP && !rx_wait && rx_os == 4'hf && !rxd &&
		rx_sh == 8'h00;
	assign ovr_ev = rx_ev && rx_full && !rx_take;

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			rx_data <= 8'h0;
			rx_full <= 1'b0;
		end
		else if (rx_ev)
		begin
			rx_data <= rx_sh;
			rx_full <= 1'b1;
		end
		else if (rx_take)
			rx_full <= 1'b0;
	end

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			deep_sleep_req <= 1'b0;
		else if (brk_ev && brk_code == UOP_BRK_SLEEP)
			deep_sleep_req <= 1'b1;
	end

	always_comb
	begin
		ev = '0;
		ev[`UOP_IRQ_BRK_BIT] = brk_ev && brk_code == UOP_BRK_EVENT;
		ev[`UOP_IRQ_CTS_BIT] = cts_notify && (ctsd != cts_q);
		ev[`UOP_IRQ_RX_BIT]  = rx_ev;
		ev[`UOP_IRQ_TX_BIT]  = tx_done;
		ev[`UOP_IRQ_OVR_BIT] = ovr_ev;
	end

	// pin drive: rts low means ready, held high while receive data waits
	always_comb
	begin
		pin_out = '1;
		pin_oe  = '0;
		pin_out[tx_pin] = txd;
		pin_oe[tx_pin]  = 1'b1;
		pin_out[rts_pin] = flow_hw ? rx_full : 1'b0;
		pin_oe[rts_pin]  = flow_hw;
	end
endmodule : uop_uart
`default_nettype wire

// >>> shared/uop_params.svh
`ifndef UOP_PARAMS_SVH
`define UOP_PARAMS_SVH
`define UOP_CLK_HZ        50000000
`define UOP_OFF_CTRL      8'h00
`define UOP_OFF_BAUD      8'h04
`define UOP_OFF_PINS      8'h08
`define UOP_OFF_STATUS    8'h0c
`define UOP_OFF_IRQ_STAT  8'h10
`define UOP_OFF_IRQ_MASK  8'h14
`define UOP_OFF_TXDATA    8'h18
`define UOP_OFF_RXDATA    8'h1c
`define UOP_CTRL_FLOW_BIT 0
`define UOP_CTRL_PAR_LO   1
`define UOP_CTRL_BRK_LO   3
`define UOP_CTRL_CTSN_BIT 5
`define UOP_CTRL_DCE_BIT  6
`define UOP_CTRL_RESET    32'h0000_0000
`define UOP_BAUD_RESET    32'h0000_0003
`define UOP_PINS_RESET    32'hffff_ffff
`define UOP_PIN_DEFAULT   8'hff
`define UOP_IRQ_BRK_BIT   0
`define UOP_IRQ_CTS_BIT   1
`define UOP_IRQ_RX_BIT    2
`define UOP_IRQ_TX_BIT    3
`define UOP_IRQ_OVR_BIT   4
`define UOP_IRQ_BITS      5
`endif

// >>> shared/uop_pkg.sv
package uop_pkg;
	typedef enum logic [1:0] {UOP_BRK_SLEEP, UOP_BRK_NONE, UOP_BRK_EVENT, UOP_BRK_RSVD} uop_brk_t;
	typedef enum logic [1:0] {UOP_PAR_NONE, UOP_PAR_ODD, UOP_PAR_EVEN, UOP_PAR_RSVD} uop_par_t;
	typedef enum {UOP_TX_IDLE, UOP_TX_START, UOP_TX_DATA, UOP_TX_STOP} uop_tx_st_t;
	typedef enum {UOP_RX_IDLE, UOP_RX_START, UOP_RX_DATA, UOP_RX_STOP} uop_rx_st_t;
endpackage : uop_pkg

// >>> logic/uop_baud_gen.sv
`timescale 1ns/1ps
`default_nettype none
`include "uop_params.svh"
module uop_baud_gen
	import uop_pkg::*;
#(
	parameter int CLK_HZ = `UOP_CLK_HZ
)(
	input  wire logic        mclk,
	input  wire logic        resetn,
	input  wire logic [3:0]  rate_sel,
	output logic      [15:0] tick_div
);
	// sixteen-times oversampling divider; cycles per tick, rounded
	function automatic logic [15:0] div_of(input int baud);
		int d;
		d = (CLK_HZ + 8 * baud) / (16 * baud);
		if (d < 1)
			d = 1;
		return d[15:0];
	endfunction : div_of

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			tick_div <= 16'h0001;
		else
			unique case (rate_sel)
				4'h0: tick_div <= div_of(1200);
				4'h1: tick_div <= div_of(2400);
				4'h2: tick_div <= div_of(4800);
				4'h3: tick_div <= div_of(9600);
				4'h4: tick_div <= div_of(14400);
				4'h5: tick_div <= div_of(19200);
				4'h6: tick_div <= div_of(28800);
				4'h7: tick_div <= div_of(38400);
				4'h8: tick_div <= div_of(57600);
				4'h9: tick_div <= div_of(76800);
				4'ha: tick_div <= div_of(115200);
				4'hb: tick_div <= div_of(230400);
				4'hc: tick_div <= div_of(250000);
				4'hd: tick_div <= div_of(460800);
				4'he: tick_div <= div_of(921600);
				4'hf: tick_div <= div_of(1000000);
			endcase
	end
endmodule : uop_baud_gen
`default_nettype wire

// >>> verif/uop_uart_sva.sv
`timescale 1ns/1ps
`default_nettype none
module uop_uart_sva (
	input wire logic       mclk,
	input wire logic       resetn,
	input wire logic       s_axi_awready,
	input wire logic       s_axi_wready,
	input wire logic       s_axi_bvalid,
	input wire logic       s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic       s_axi_arvalid,
	input wire logic       s_axi_arready,
	input wire logic       s_axi_rvalid,
	input wire logic       s_axi_rready,
	input wire logic [1:0] s_axi_rresp,
	input wire logic       deep_sleep_req
);
	logic [7:0] ra;
	// address of the read in flight, for the response code
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			ra <= 8'h00;
		else if (s_axi_arvalid && s_axi_arready)
			ra <= s_axi_araddr;
	end
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!resetn);
	w_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted while response pending");
	ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read accepted while data pending");
	rd_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	b_cause_a: assert property ($rose(s_axi_bvalid) |-> $past(!s_axi_awready && !s_axi_wready))
		else $error("write response without request");
	r_cause_a: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready))
		else $error("read data without request");
	b_drop_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response repeated");
	r_drop_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read data repeated");
	sleep_hold_a: assert property (deep_sleep_req |=> deep_sleep_req)
		else $error("sleep request dropped");
	rresp_map_a: assert property (s_axi_rvalid && ra != 8'h18 |->
		s_axi_rresp == ((ra[1:0] == 2'b00 && ra <= 8'h1c) ? 2'b00 : 2'b10))
		else $error("wrong read response code");
endmodule : uop_uart_sva
bind uop_uart uop_uart_sva u_sva (.*);
`default_nettype wire

// >>> verif/uop_remote.sv
`timescale 1ns/1ps
`default_nettype none
module uop_remote #(
	parameter int BIT_CYC = 48
)(
	input  wire logic mclk,
	input  wire logic txd,
	output logic      rxd,
	output logic      cts
);
	logic [7:0] got;
	logic       got_stop;
	int         n_got;
	initial
	begin
		rxd = 1'b1;
		cts = 1'b0;
		n_got = 0;
	end
	// handshake line changes right after a clock edge, like the bench inputs
	task automatic set_cts(input logic v);
		cts <= v;
	endtask : set_cts
	// zero data with low stop makes a break; line returns high after
	task automatic send(input logic [7:0] d, input logic stp);
		logic [9:0] f;
		f = {stp, d, 1'b0};
		for (int i = 0; i < 10; i++)
			repeat (BIT_CYC) @(posedge mclk) rxd <= f[i];
		repeat (BIT_CYC) @(posedge mclk) rxd <= 1'b1;
	endtask : send
	// mid-bit sampling, 48 clocks a bit at the fastest rate
	always
	begin
		@(negedge txd);
		repeat (BIT_CYC / 2) @(posedge mclk);
		for (int i = 0; i < 8; i++)
		begin
			repeat (BIT_CYC) @(posedge mclk);
			got[i] = txd;
		end
		repeat (BIT_CYC) @(posedge mclk);
		got_stop = txd;
		n_got++;
	end
endmodule : uop_remote
`default_nettype wire

// >>> verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic        mclk, resetn, txd, rxd, cts, irq, deep_sleep_req;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
	logic [3:0]  s_axi_wstrb;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, pin_in, pin_out, pin_oe, rv;
	logic [1:0]  bc [3] = '{2'd1, 2'd2, 2'd0};
	int          errors, n_checks, txp, n0;
	uop_uart uut (.*);
	uop_remote rem (.*);
	assign txd = pin_oe[txp] ? pin_out[txp] : 1'b1;
	always_comb
	begin
		pin_in = 32'hffff_ffff;
		pin_in[8] = rxd;
		pin_in[7] = cts;
	end
	initial
	begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : tally_and_finish
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e)
		begin
			errors++;
			$display("[FAIL] %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task automatic tmo(input bit ok);
		if (!ok)
		begin
			errors++;
			tally_and_finish();
		end
	endtask : tmo
	// ready is looked at before the edge that takes it
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bit aw, w, b;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		for (int n = 0; n < 50 && !b; n++)
		begin
			@(negedge mclk);
			aw = s_axi_awvalid && s_axi_awready;
			w = s_axi_wvalid && s_axi_wready;
			b = s_axi_bvalid;
			rs = s_axi_bresp;
			@(posedge mclk);
			if (aw)
				s_axi_awvalid <= 1'b0;
			if (w)
				s_axi_wvalid <= 1'b0;
		end
		tmo(b);
	endtask : wr
	task automatic rd(input logic [7:0] a);
		bit ar, r;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		for (int n = 0; n < 50 && !r; n++)
		begin
			@(negedge mclk);
			ar = s_axi_arvalid && s_axi_arready;
			r = s_axi_rvalid;
			rv = s_axi_rdata;
			rs = s_axi_rresp;
			@(posedge mclk);
			if (ar)
				s_axi_arvalid <= 1'b0;
		end
		tmo(r);
	endtask : rd
	task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		rd(a);
		chk($sformatf("reg %h", a), e, rv & m);
	endtask : rdc
	task automatic wait_tx;
		for (int n = 0; n < 2000 && rem.n_got == n0; n++)
			@(posedge mclk);
		tmo(rem.n_got != n0);
	endtask : wait_tx
	initial
	begin
		resetn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'b000;
		{s_axi_bready, s_axi_rready} = 2'b11;
		s_axi_wstrb = 4'hf;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_wdata = 32'h0;
		errors = 0;
		n_checks = 0;
		txp = 6;
		repeat (8) @(posedge mclk);
		resetn <= 1'b1;
		@(posedge mclk);
		chk("irq", 0, irq);
		chk("rts oe", 0, pin_oe[5]);
		rdc(8'h00, 32'h7f, 32'h0);
		rdc(8'h04, 32'hffff_ffff, 32'h3);
		rdc(8'h08, 32'hffff_ffff, 32'hffff_ffff);
		rd(8'h40);
		chk("rresp", 2'b10, rs);
		wr(8'h0c, 32'h1);
		chk("bresp", 2'b10, rs);
		for (int i = 0; i < 16; i++)
		begin
			wr(8'h04, 32'(i));
			rdc(8'h04, 32'hf, 32'(i));
		end
		wr(8'h00, 32'h37);
		rdc(8'h00, 32'h7f, 32'h31);
		chk("rts oe", 1, pin_oe[5]);
		chk("rts", 0, pin_out[5]);
		rd(8'h10);
		n0 = rem.n_got;
		rem.set_cts(1'b1);
		wr(8'h18, 32'h0);
		rdc(8'h0c, 32'hf, 32'h9);
		repeat (300) @(posedge mclk);
		chk("held", n0, rem.n_got);
		rem.set_cts(1'b0);
		wait_tx();
		chk("tx", 0, rem.got);
		chk("stop", 1, rem.got_stop);
		repeat (48) @(posedge mclk);
		rd(8'h10);
		chk("cts ev", 32'ha, rv & 32'ha);
		wr(8'h08, 32'hffff_0aff);
		txp = 10;
		n0 = rem.n_got;
		wr(8'h18, 32'ha5);
		wait_tx();
		chk("tx pin", 32'ha5, rem.got);
		chk("old oe", 0, pin_oe[6]);
		wr(8'h08, 32'hffff_ffff);
		txp = 6;
		wr(8'h00, 32'h11);
		repeat (48) @(posedge mclk);
		rd(8'h10);
		rem.set_cts(1'b1);
		repeat (20) @(posedge mclk);
		rem.set_cts(1'b0);
		repeat (20) @(posedge mclk);
		rd(8'h10);
		chk("cts off", 0, rv[1]);
		wr(8'h14, 32'h4);
		rem.send(8'h3c, 1'b1);
		chk("irq rx", 1, irq);
		chk("rts full", 1, pin_out[5]);
		rdc(8'h1c, 32'hff, 32'h3c);
		rd(8'h10);
		chk("rx ev", 1, rv[2]);
		chk("irq clr", 0, irq);
		chk("rts free", 0, pin_out[5]);
		wr(8'h14, 32'h0);
		rem.send(8'h81, 1'b1);
		chk("irq mask", 0, irq);
		rdc(8'h1c, 32'hff, 32'h81);
		wr(8'h14, 32'h1);
		foreach (bc[i])
		begin
			wr(8'h00, {27'h0, bc[i], 3'h0});
			rd(8'h10);
			rem.send(8'h00, 1'b0);
			chk("brk irq", bc[i] == 2'd2, irq);
			chk("sleep", bc[i] == 2'd0, deep_sleep_req);
		end
		wr(8'h00, 32'h18);
		rdc(8'h00, 32'h18, 32'h0);
		tally_and_finish();
	end
endmodule : tb_top
`default_nettype wire
